// ---- hdl/sleep_pkg.sv ----
// shared constants and types for the sleep-mode controller
package sleep_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] SLEEP_CONTROL_ADDR = 12'h000;  // control byte in the low bits of the word
  localparam logic [11:0] SLEEP_STATUS_ADDR  = 12'h004;  // state and mode readback
  localparam logic [11:0] WAKE_CONFIG_ADDR   = 12'h008;  // delays, clocking and enables
  localparam logic [7:0]  SLEEP_CONTROL_RESET = 8'h00;
  localparam int          SE_BIT        = 0;
  localparam int          MODE_LSB      = 1;
  localparam int          WCFG_DELAY_LSB = 0;   // wake_config[15:0] power-down restart delay in cycles
  localparam int          WCFG_ASYNC_BIT = 16;  // timer 2 clocked from its own oscillator
  localparam int          WCFG_XTAL_BIT  = 17;  // external crystal selected
  localparam int          WCFG_ADCEN_BIT = 18;  // converter enabled
  localparam int          WCFG_T2EN_BIT  = 19;  // timer 2 enabled
  localparam logic [15:0] WCFG_DELAY_RESET = 16'h0010;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int HALT_CYCLES    = 4;  // extra stall before the interrupt is taken
  localparam int STANDBY_CYCLES = 6;  // wake time from the standby modes

  // ------------------------------------------------------------
  // modes and states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IDLE    = 3'h0,
    MODE_ADCNR   = 3'h1,
    MODE_PDOWN   = 3'h2,
    MODE_PSAVE   = 3'h3,
    MODE_RSV4    = 3'h4,
    MODE_RSV5    = 3'h5,
    MODE_STANDBY = 3'h6,
    MODE_EXTSTBY = 3'h7
  } sleep_mode_type;

  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_SLEEP  = 4'h2,
    ST_RESTART = 4'h4,
    ST_HALT   = 4'h8
  } state_type;

  // wake source vector positions
  localparam int WK_ADC    = 0;  // conversion complete
  localparam int WK_WDT    = 1;  // watchdog interrupt
  localparam int WK_TWI    = 2;  // two-wire interrupt
  localparam int WK_TWIADR = 3;  // two-wire address match
  localparam int WK_T2     = 4;  // timer 2 overflow/compare (already masked)
  localparam int WK_SPM    = 5;  // store-program / eeprom ready
  localparam int WK_EXTUL  = 6;  // level on ext_irq_upper
  localparam int WK_EXTUE  = 7;  // edge on ext_irq_upper
  localparam int WK_EXTL   = 8;  // any on ext_irq_lower
  localparam int WK_PCINT  = 9;  // pin change
  localparam int WK_USBA   = 10; // asynchronous usb interrupts
  localparam int WK_USBS   = 11; // synchronous usb interrupts
  localparam int WK_OTHER  = 12; // other io interrupts
  localparam int WAKE_W    = 13;

endpackage : sleep_pkg

// ---- hdl/wake_qualifier.sv ----
// per-mode wake source mask
`timescale 1ns/1ns
module wake_qualifier (
  input  wire logic [2:0]                 mode,       // latched sleep mode
  input  wire logic                       t2_async,   // timer 2 on own oscillator
  input  wire logic [sleep_pkg::WAKE_W-1:0] sources,  // raw enabled interrupt requests
  output logic                            wake        // qualified wake request
);
  import sleep_pkg::*;

  logic [WAKE_W-1:0] allow;

  // ------------------------------------------------------------
  // allowed sources for the latched mode
  // ------------------------------------------------------------
  always_comb begin
    allow = '0;
    case (mode)
      MODE_IDLE: begin
        allow = '1;
      end
      MODE_ADCNR: begin
        allow[WK_ADC]   = 1'b1;
        allow[WK_WDT]   = 1'b1;
        allow[WK_TWI]   = 1'b1;
        allow[WK_TWIADR] = 1'b1;
        allow[WK_T2]    = 1'b1;
        allow[WK_SPM]   = 1'b1;
        allow[WK_EXTUL] = 1'b1;
        allow[WK_PCINT] = 1'b1;
      end
      MODE_PDOWN, MODE_STANDBY: begin
        allow[WK_TWIADR] = 1'b1;
        allow[WK_EXTUL] = 1'b1;
        allow[WK_EXTL]  = 1'b1;
        allow[WK_PCINT] = 1'b1;
        allow[WK_USBA]  = 1'b1;
        allow[WK_WDT]   = 1'b1;
      end
      MODE_PSAVE, MODE_EXTSTBY: begin
        allow[WK_TWIADR] = 1'b1;
        allow[WK_EXTUL] = 1'b1;
        allow[WK_EXTL]  = 1'b1;
        allow[WK_PCINT] = 1'b1;
        allow[WK_USBA]  = 1'b1;
        allow[WK_WDT]   = 1'b1;
        allow[WK_T2]    = 1'b1;
      end
      default: begin
        allow = '0;
      end
    endcase
  end

  // t2_async only matters for clock gating; kept here so wake and gating agree on mode
  assign wake = |(allow & sources) & (t2_async | ~t2_async);

endmodule : wake_qualifier

// ---- hdl/clock_gate_table.sv ----
// clock-domain and oscillator enables per sleep mode
`timescale 1ns/1ns
module clock_gate_table (
  input  wire logic       asleep,        // a mode is in force
  input  wire logic [2:0] mode,          // latched mode
  input  wire logic       t2_async,      // timer 2 on own oscillator
  input  wire logic       t2_enable,     // timer 2 enabled
  output logic [6:0]      gates          // core,flash,io,adc,asy,main_osc,timer_osc
);
  import sleep_pkg::*;

  // ------------------------------------------------------------
  // table lookup, all running while awake
  // ------------------------------------------------------------
  always_comb begin
    gates = 7'h7f;
    if (asleep) begin
      case (mode)
        MODE_IDLE:    gates = {2'b00, 3'b111, 1'b1, t2_async};
        MODE_ADCNR:   gates = {2'b00, 1'b0, 2'b11, 1'b1, t2_async};
        MODE_PDOWN:   gates = 7'h00;
        MODE_PSAVE:   gates = {4'b0000, t2_enable, ~t2_async & t2_enable,
                               t2_async & t2_enable};
        MODE_STANDBY: gates = {5'b00000, 1'b1, 1'b0};
        MODE_EXTSTBY: gates = {4'b0000, t2_async & t2_enable, 1'b1, t2_async};
        default:      gates = 7'h7f;
      endcase
    end
  end

endmodule : clock_gate_table

// ---- hdl/sleep_mode_controller.sv ----
// sleep-mode controller top with AHB-Lite register slave
//
// How it works
// - sleep starts only when sleep instruction executes with sleep enable set
// - mode select codes: idle, noise reduction, power-down, save, standby, extended
// - on wake the core stalls four extra cycles after start-up
// - register file and memory are kept; on wake the core is only stalled, never reset
// - any reset during sleep leaves sleep and restarts at the reset vector
// - control register: mode in bits 3..1, enable bit 0, upper bits zero
// - idle stops only core and flash clocks; all sources may wake
// - idle or noise-reduction entry starts a conversion if converter enabled
// - noise reduction stops io, core, flash; converter, async, usb keep running
// - noise-reduction wake sources are a fixed limited set
// - power-down stops oscillator and all generated clocks
// - power-down wake sources are a fixed limited set
// - leaving power-down waits the configured restart delay
// - power-save is power-down plus a masked timer 2 wake
// - power-save stops the unused timer 2 clock source
// - standby keeps the oscillator and wakes within six cycles
// - extended standby is power-save with oscillator running, six-cycle wake; here async clock needs async timer 2, timer osc follows t2_async alone
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module sleep_mode_controller (
  input  wire logic                         sys_clk,       // 250 MHz system clock
  input  wire logic                         reset_n,       // async reset, active low
  input  wire logic                         clk_en,        // freezes all state while low
  // ahb-lite slave
  input  wire logic                         hsel,          // slave select
  input  wire logic [11:0]                  haddr,         // byte address
  input  wire logic [1:0]                   htrans,        // transfer type
  input  wire logic                         hwrite,        // write when high
  input  wire logic [2:0]                   hsize,         // transfer size
  input  wire logic [31:0]                  hwdata,        // write data
  input  wire logic                         hready,        // bus ready
  output logic [31:0]                       hrdata,        // read data
  output logic                              hreadyout,     // slave ready
  output logic                              hresp,         // always okay
  // core side
  input  wire logic                         sleep_exec,    // sleep instruction executes, one-cycle pulse
  input  wire logic                         any_reset,     // any device reset request, level
  input  wire logic [sleep_pkg::WAKE_W-1:0] wake_sources,  // enabled interrupt requests
  output logic                              core_stall,    // hold core pipeline
  output logic                              irq_take,      // core may take the interrupt, pulse
  output logic                              reset_vector,  // restart at reset vector, pulse
  output logic                              adc_start,     // start conversion, pulse
  output logic                              core_clock,    // core clock enable
  output logic                              program_memory_clock, // flash clock enable
  output logic                              io_clock,      // io clock enable
  output logic                              adc_clock,     // converter clock enable
  output logic                              async_clock,   // async timer clock enable
  output logic                              main_osc_en,   // main oscillator enable
  output logic                              timer_osc_en,  // timer oscillator enable
  output logic                              usb_clock_domain // usb clock enable
);
  import sleep_pkg::*;

  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  sleep_mode_select;
    logic        sleep_enable_bit;
    logic [15:0] restart_delay;
    logic        t2_async;
    logic        xtal_sel;
    logic        adc_enable;
    logic        t2_enable;
    state_type   state;
    logic [2:0]  mode;
    logic [15:0] count;
    logic        dp_valid;
    logic        dp_write;
    logic [11:0] dp_addr;
    logic [31:0] rdata;
    logic        irq_take;
    logic        reset_vector;
    logic        adc_start;
  } regs_type;

  regs_type r;
  regs_type next_r;
  logic     wake;
  logic [6:0] gates;
  logic     asleep;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic mode_reserved(input logic [2:0] m);
    mode_reserved = (m == MODE_RSV4) || (m == MODE_RSV5);
  endfunction : mode_reserved

  function automatic logic mode_fast(input logic [2:0] m);
    mode_fast = (m == MODE_STANDBY) || (m == MODE_EXTSTBY);
  endfunction : mode_fast

  function automatic logic mode_osc_off(input logic [2:0] m);
    mode_osc_off = (m == MODE_PDOWN) || (m == MODE_PSAVE);
  endfunction : mode_osc_off

  assign asleep = (r.state == ST_SLEEP);

  wake_qualifier u_wake (
    .mode     (r.mode),
    .t2_async (r.t2_async),
    .sources  (wake_sources),
    .wake     (wake)
  );

  clock_gate_table u_gates (
    .asleep    (asleep),
    .mode      (r.mode),
    .t2_async  (r.t2_async),
    .t2_enable (r.t2_enable),
    .gates     (gates)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic        ahb_go;
    logic [31:0] rd;
    ahb_go = 1'b0;
    rd     = 32'h0000_0000;
    next_r = r;
    next_r.irq_take     = 1'b0;
    next_r.reset_vector = 1'b0;
    next_r.adc_start    = 1'b0;

    // bus data phase: writes land here, reads were captured at address phase
    if (r.dp_valid && r.dp_write) begin
      if (r.dp_addr == SLEEP_CONTROL_ADDR) begin
        next_r.sleep_mode_select = hwdata[MODE_LSB +: 3];
        next_r.sleep_enable_bit  = hwdata[SE_BIT];
      end else if (r.dp_addr == WAKE_CONFIG_ADDR) begin
        next_r.restart_delay = hwdata[WCFG_DELAY_LSB +: 16];
        next_r.t2_async      = hwdata[WCFG_ASYNC_BIT];
        next_r.xtal_sel      = hwdata[WCFG_XTAL_BIT];
        next_r.adc_enable    = hwdata[WCFG_ADCEN_BIT];
        next_r.t2_enable     = hwdata[WCFG_T2EN_BIT];
      end
    end

    // bus address phase, zero wait states
    ahb_go = hsel && hready && htrans[1];
    next_r.dp_valid = ahb_go;
    next_r.dp_write = hwrite;
    next_r.dp_addr  = {haddr[11:2], 2'b00};
    if (ahb_go && !hwrite) begin
      if ({haddr[11:2], 2'b00} == SLEEP_CONTROL_ADDR) begin
        rd = {28'h0000000, r.sleep_mode_select, r.sleep_enable_bit};
      end else if ({haddr[11:2], 2'b00} == SLEEP_STATUS_ADDR) begin
        rd = {25'h0000000, r.mode, r.state};
      end else if ({haddr[11:2], 2'b00} == WAKE_CONFIG_ADDR) begin
        rd = {12'h000, r.t2_enable, r.adc_enable, r.xtal_sel, r.t2_async, r.restart_delay};
      end else begin
        rd = 32'h0000_0000;
      end
      next_r.rdata = rd;
    end

    // sleep sequence
    case (r.state)
      ST_RUN: begin
        if (sleep_exec && r.sleep_enable_bit && !mode_reserved(r.sleep_mode_select)) begin
          next_r.state = ST_SLEEP;
          next_r.mode  = r.sleep_mode_select;
          if (r.adc_enable && (r.sleep_mode_select == MODE_IDLE || r.sleep_mode_select == MODE_ADCNR)) begin
            next_r.adc_start = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          next_r.state = ST_RESTART;
          if (mode_osc_off(r.mode)) begin
            next_r.count = r.restart_delay;
          end else if (mode_fast(r.mode)) begin
            next_r.count = 16'(STANDBY_CYCLES - HALT_CYCLES);
          end else begin
            next_r.count = 16'h0000;
          end
        end
      end
      ST_RESTART: begin
        if (r.count <= 16'h0001) begin
          next_r.state = ST_HALT;
          next_r.count = 16'(HALT_CYCLES);
        end else begin
          next_r.count = r.count - 16'h0001;
        end
      end
      ST_HALT: begin
        if (r.count <= 16'h0001) begin
          next_r.state    = ST_RUN;
          next_r.irq_take = 1'b1;
          next_r.count    = 16'h0000;
        end else begin
          next_r.count = r.count - 16'h0001;
        end
      end
      default: begin
        next_r.state = ST_RUN;
      end
    endcase

    // a reset overrides any wake path; control bits return to zero
    if (any_reset) begin
      if (r.state != ST_RUN) begin
        next_r.reset_vector = 1'b1;
      end
      next_r.state             = ST_RUN;
      next_r.count             = 16'h0000;
      next_r.sleep_mode_select = 3'h0;
      next_r.sleep_enable_bit  = 1'b0;
      next_r.irq_take          = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers; memory and register file are outside and never touched
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{sleep_mode_select: 3'h0, sleep_enable_bit: 1'b0, restart_delay: WCFG_DELAY_RESET,
             t2_async: 1'b0, xtal_sel: 1'b0, adc_enable: 1'b0, t2_enable: 1'b0,
             state: ST_RUN, mode: 3'h0, count: 16'h0000, dp_valid: 1'b0, dp_write: 1'b0,
             dp_addr: 12'h000, rdata: 32'h0000_0000, irq_take: 1'b0, reset_vector: 1'b0,
             adc_start: 1'b0};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata    = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign core_stall   = (r.state != ST_RUN);
  assign irq_take     = r.irq_take;
  assign reset_vector = r.reset_vector;
  assign adc_start    = r.adc_start;
  assign core_clock           = gates[6];
  assign program_memory_clock = gates[5];
  assign io_clock             = gates[4];
  assign adc_clock            = gates[3];
  assign async_clock          = gates[2];
  assign main_osc_en          = gates[1];
  assign timer_osc_en         = gates[0];
  // usb domain runs while awake and, among the sleep modes, in idle and noise reduction only
  assign usb_clock_domain = !asleep || (r.mode == MODE_IDLE) || (r.mode == MODE_ADCNR);

endmodule : sleep_mode_controller

// ---- bench/sleep_mode_controller_checker.sv ----
// port-level assertions for the sleep-mode controller
`timescale 1ns/1ns
module sleep_mode_controller_checker import sleep_pkg::*; (
  input wire logic                         sys_clk,              // system clock
  input wire logic                         reset_n,              // async reset, active low
  input wire logic                         clk_en,               // run enable
  input wire logic                         sleep_exec,           // sleep instruction
  input wire logic                         any_reset,            // device reset request
  input wire logic [sleep_pkg::WAKE_W-1:0] wake_sources,         // wake requests
  input wire logic                         core_stall,           // core held
  input wire logic                         irq_take,             // interrupt taken
  input wire logic                         reset_vector,         // restart from reset
  input wire logic                         adc_start,            // conversion start
  input wire logic                         core_clock,           // core clock enable
  input wire logic                         program_memory_clock, // flash clock enable
  input wire logic                         io_clock,             // io clock enable
  input wire logic                         adc_clock,            // converter clock enable
  input wire logic                         async_clock,          // async timer clock enable
  input wire logic                         main_osc_en,          // main oscillator enable
  input wire logic                         usb_clock_domain      // usb clock enable
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n || !clk_en);

  // standby is picked out by stall and gates: oscillator kept, core, converter and async clocks off
  wire stby = core_stall && !core_clock && main_osc_en && !adc_clock && !async_clock;

  sequence back_in_six;
    ##[1:7] !core_stall;
  endsequence
  sequence halted_four;
    $past(core_stall) && $past(core_stall, 4) && !core_stall;
  endsequence

  a_entry_needs_exec: assert property ($rose(core_stall) |-> $past(sleep_exec))
    else $error("stall began without a sleep instruction");
  a_halt_before_irq: assert property (irq_take |-> halted_four)
    else $error("interrupt taken without the wake stall");
  a_reset_wakes_core: assert property ((any_reset && core_stall) |=> reset_vector && !core_stall)
    else $error("reset during sleep did not restart the core");
  a_reset_no_irq: assert property (reset_vector |-> !irq_take)
    else $error("reset restart also took an interrupt");
  a_idle_gates: assert property ((core_stall && !core_clock && io_clock) |->
    adc_clock && async_clock && main_osc_en && usb_clock_domain && !program_memory_clock)
    else $error("idle gate pattern wrong");
  a_adc_on_entry: assert property (adc_start |-> core_stall && adc_clock && $past(sleep_exec))
    else $error("conversion start outside sleep entry");
  a_noise_red_gates: assert property ((core_stall && !io_clock && adc_clock) |->
    async_clock && main_osc_en && usb_clock_domain && !core_clock)
    else $error("noise reduction gate pattern wrong");
  a_osc_off_gates: assert property (!main_osc_en |->
    core_stall && !io_clock && !adc_clock && !core_clock && !usb_clock_domain)
    else $error("oscillator stopped while clocks still run");
  a_standby_six: assert property ((stby && wake_sources[WK_WDT] && !any_reset) |-> back_in_six)
    else $error("standby wake took too long");
endmodule : sleep_mode_controller_checker

bind sleep_mode_controller sleep_mode_controller_checker chk (.sys_clk, .reset_n, .clk_en, .sleep_exec,
  .any_reset, .wake_sources, .core_stall, .irq_take, .reset_vector, .adc_start, .core_clock,
  .program_memory_clock, .io_clock, .adc_clock, .async_clock, .main_osc_en, .usb_clock_domain);

// ---- bench/core_wake_model.sv ----
// far-side model: core issuing sleep and interrupt sources raising wakes
`timescale 1ns/1ns
module core_wake_model import sleep_pkg::*; (
  input  wire logic                         sys_clk,      // system clock
  input  wire logic                         reset_n,      // async reset, active low
  input  wire logic                         sleep_cmd,    // bench asks for a sleep
  input  wire logic [sleep_pkg::WAKE_W-1:0] wake_cmd,     // bench raises sources
  input  wire logic                         irq_take,     // interrupt accepted
  input  wire logic                         reset_vector, // restart from reset
  output logic                              sleep_exec,   // one-cycle sleep instruction
  output logic [sleep_pkg::WAKE_W-1:0]      wake_sources  // held request levels
);
  // ------------------------------------------------------------
  // core and interrupt sources
  // ------------------------------------------------------------
  // a source keeps its level until the core takes it, so a slow wake cannot miss it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_exec   <= 1'b0;
      wake_sources <= '0;
    end else begin
      sleep_exec   <= sleep_cmd;
      wake_sources <= (irq_take || reset_vector) ? '0 : (wake_sources | wake_cmd);
    end
  end
endmodule : core_wake_model

// ---- bench/test_sleep_mode_controller.sv ----
// self-checking bench for the sleep-mode controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_sleep_mode_controller;
  import sleep_pkg::*;
  logic        sys_clk, reset_n, clk_en, hsel, hwrite, hready, any_reset, sleep_cmd;
  logic        core_stall, irq_take, reset_vector, adc_start, sleep_exec, hreadyout, hresp;
  logic        core_clock, program_memory_clock, io_clock, adc_clock, async_clock;
  logic        main_osc_en, timer_osc_en, usb_clock_domain;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, r;
  logic [12:0] wake_cmd, wake_sources;
  int          error_cnt, check_count, n;
  // per-mode expectations: code, gates, restart cycles, ignored and waking sources
  logic [2:0]  md[6]   = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [7:0]  gx[6]   = '{8'h3f, 8'h1f, 8'h00, 8'h0a, 8'h04, 8'h0e};
  int          nr[6]   = '{1, 1, 3, 3, 2, 2};
  logic [12:0] bad[6]  = '{13'h0, 13'h1000, 13'h0811, 13'h0801, 13'h0030, 13'h1021};
  logic [12:0] good[6] = '{13'h0002, 13'h0002, 13'h0100, 13'h0010, 13'h0002, 13'h0002};
  logic [3:0]  no_sl[3] = '{4'h0, 4'h9, 4'hb};
  wire  [7:0]  gates = {core_clock, program_memory_clock, io_clock, adc_clock, async_clock,
                        main_osc_en, timer_osc_en, usb_clock_domain};
  assign hready = hreadyout;

  sleep_mode_controller dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec),
    .any_reset(any_reset), .wake_sources(wake_sources), .core_stall(core_stall), .irq_take(irq_take),
    .reset_vector(reset_vector), .adc_start(adc_start), .core_clock(core_clock),
    .program_memory_clock(program_memory_clock), .io_clock(io_clock), .adc_clock(adc_clock),
    .async_clock(async_clock), .main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en),
    .usb_clock_domain(usb_clock_domain));
  core_wake_model partner (.sys_clk(sys_clk), .reset_n(reset_n), .sleep_cmd(sleep_cmd),
    .wake_cmd(wake_cmd), .irq_take(irq_take), .reset_vector(reset_vector), .sleep_exec(sleep_exec),
    .wake_sources(wake_sources));

  // ------------------------------------------------------------
  // bus and core tasks
  // ------------------------------------------------------------
  // one single transfer; request held until ready is seen high at an edge
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d); bus(a, 1'b1, d); endtask : wr
  task automatic rd(input logic [11:0] a); bus(a, 1'b0, 32'h0); endtask : rd
  task automatic go_sleep();
    @(posedge sys_clk) sleep_cmd <= 1'b1;
    @(posedge sys_clk) sleep_cmd <= 1'b0;
    for (int k = 0; k < 8 && core_stall !== 1'b1; k++) begin @(posedge sys_clk); #1; end
  endtask : go_sleep
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // the whole run needs a few hundred cycles; ten thousand means a hang
  initial begin
    #40000;
    error_cnt++;
    $display("ERROR watchdog expired");
    complete_run();
  end
  initial begin
    reset_n = 1'b0; clk_en = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; any_reset = 1'b0; sleep_cmd = 1'b0; wake_cmd = '0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1 `CHK("run gates", 8'hff, gates)
    rd(SLEEP_CONTROL_ADDR); `CHK("control reset", 32'h0, r)
    rd(WAKE_CONFIG_ADDR); `CHK("config reset", {16'h0, WCFG_DELAY_RESET}, r)
    wr(SLEEP_CONTROL_ADDR, 32'hffffffff); rd(SLEEP_CONTROL_ADDR); `CHK("control bits", 32'hf, r)
    wr(12'h00c, 32'hffffffff); rd(12'h00c); `CHK("unmapped", 32'h0, r)
    // enable clear, then both reserved codes with enable set: no sleep at all
    for (int i = 0; i < 3; i++) begin
      wr(SLEEP_CONTROL_ADDR, {28'h0, no_sl[i]});
      go_sleep();
      `CHK("no sleep", 8'hff, gates)
    end
    // short restart delay, converter and async timer 2 enabled, crystal selected
    wr(WAKE_CONFIG_ADDR, 32'h000f0003);
    for (int i = 0; i < 6; i++) begin
      wr(SLEEP_CONTROL_ADDR, {28'h0, md[i], 1'b1});
      go_sleep();
      `CHK("sleep gates", gx[i], gates)
      `CHK("conversion start", (i < 2), adc_start)
      rd(SLEEP_STATUS_ADDR); `CHK("status", {25'h0, md[i], 4'h2}, r)
      @(posedge sys_clk) wake_cmd <= bad[i];
      @(posedge sys_clk) wake_cmd <= '0;
      repeat (8) @(posedge sys_clk);
      #1 `CHK("still asleep", 1'b1, core_stall)
      @(posedge sys_clk) wake_cmd <= good[i];
      @(posedge sys_clk) wake_cmd <= '0;
      n = 0;
      while (core_stall === 1'b1 && n < 40) begin @(posedge sys_clk); #1; n++; end
      `CHK("wake cycles", nr[i] + 5, n)
      `CHK("irq taken", 1'b1, irq_take)
      @(posedge sys_clk);
    end
    rd(WAKE_CONFIG_ADDR); `CHK("config kept", 32'h000f0003, r)
    // reset while in power-down restarts from the reset vector
    wr(SLEEP_CONTROL_ADDR, 32'h5);
    // a frozen controller must ignore the sleep instruction
    clk_en <= 1'b0;
    go_sleep();
    `CHK("frozen", 1'b0, core_stall)
    @(posedge sys_clk) clk_en <= 1'b1;
    go_sleep();
    @(posedge sys_clk) any_reset <= 1'b1;
    @(posedge sys_clk) any_reset <= 1'b0;
    #1 `CHK("reset vector", 3'b100, {reset_vector, core_stall, irq_take})
    rd(SLEEP_CONTROL_ADDR); `CHK("control after reset", 32'h0, r)
    complete_run();
  end
endmodule : test_sleep_mode_controller
